//--- hw/tcrc_defs.svh
// Offsets, field positions, reset values and timing counts of the
// third timer/counter block.
// Assumes an 8-bit APB byte address and 32-bit data words.
`ifndef TCRC_DEFS_SVH
`define TCRC_DEFS_SVH

// --------------------------------------------------------------
// Register byte offsets
// --------------------------------------------------------------
`define TCRC_OFS_CONTROL    8'h00
`define TCRC_OFS_MODE       8'h04
`define TCRC_OFS_COUNT      8'h08
`define TCRC_OFS_RELOAD     8'h0C
`define TCRC_OFS_INT_ENABLE 8'h10

// --------------------------------------------------------------
// Control register fields (bit positions)
// --------------------------------------------------------------
`define TCRC_CTL_CAPTURE_RELOAD_SEL 0
`define TCRC_CTL_TIMER_COUNTER_SEL  1
`define TCRC_CTL_RUN_CONTROL        2
`define TCRC_CTL_EXT_TRIGGER_EN     3
`define TCRC_CTL_TX_BAUD_SEL        4
`define TCRC_CTL_RX_BAUD_SEL        5
`define TCRC_CTL_EXT_EVENT_FLAG     6
`define TCRC_CTL_OVERFLOW_FLAG      7

// --------------------------------------------------------------
// Mode register and interrupt enable fields
// --------------------------------------------------------------
`define TCRC_MODE_DOWN_COUNT_EN     0
`define TCRC_MODE_CLOCK_OUT_EN      1
`define TCRC_IE_TIMER_EN            0

// --------------------------------------------------------------
// Reset values
// --------------------------------------------------------------
`define TCRC_CONTROL_RST    8'h00
`define TCRC_MODE_RST       2'h0
`define TCRC_COUNT_RST      16'h0000
`define TCRC_RELOAD_RST     16'h0000
`define TCRC_COUNT_TOP      16'hFFFF

// --------------------------------------------------------------
// Timing: oscillator periods per increment
// --------------------------------------------------------------
`define TCRC_MACHINE_DIV    4'hC
`define TCRC_STATE_DIV      4'h2

`endif

//--- hw/tcrc_pkg.sv
// Types shared by the third timer/counter block.
// Assumes the constants of tcrc_defs.svh are used alongside.
`default_nettype none

package tcrc_pkg;
  // ------------------------------------------------------------
  // Operating mode picked from the control bits
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TCRC_MODE_RELOAD,
    TCRC_MODE_CAPTURE,
    TCRC_MODE_BAUD
  } tcrc_mode_e;

  // Register index after address decode
  typedef logic [2:0] tcrc_index_t;
endpackage

`default_nettype wire

//--- hw/tcrc_fall_detect.sv
// Falling-edge detector for a group of synchronous pin inputs.
// Assumes the inputs are already synchronous to sys_clk_in.
`default_nettype none

module tcrc_fall_detect #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  // Pin levels and edge pulses
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] fall_out
);

  // --------------------------------------------------------------
  // One flop and one gate per pin
  // --------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      // Each pin keeps its own last level, one driver per flop
      logic last_reg;

      // Idle level is high, so no false edge right after reset
      always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
          last_reg <= 1'b1;
        end else begin
          last_reg <= level_in[i];
        end
      end
      assign fall_out[i] = last_reg & ~level_in[i];
    end
  endgenerate

endmodule

`default_nettype wire

//--- hw/tcrc_top.sv
// Third 16-bit timer/counter with capture, auto-reload, baud tick
// and clock-out, reached over APB.
// Assumes pins are synchronous to sys_clk_in, which is the oscillator.
//
// How it works
// - count source is machine-cycle pulses (state-time pulses in baud or clock-out) or count-pin falls, by select bit
// - capture, auto-reload or baud generator mode from control bits
// - capture mode, trigger off: plain 16-bit count, overflow sets flag
// - capture mode, trigger on: trigger fall copies count to reload bytes
// - capture trigger sets event flag; both flags share one interrupt
// - capture mode never reloads; count continues after a capture
// - down-count enable resets to zero, so reload mode counts up
// - down-count enable in reload mode lets trigger pin level choose direction
// - up reload, trigger off: overflow at FFFF sets flag and reloads
// - up reload, trigger on: trigger fall also reloads and sets event flag
// - interrupt requested when enabled and either flag is set
// - shared pin is the count input in counter operation
// - shared pin can carry a 50% duty clock
// - no overflow flag from rollovers while clock-out runs
// - clock-out and baud tick come from the same rollover
// - down mode, trigger high: count up, flag and reload at FFFF
// - down mode, trigger low: count down, flag at reload value, load FFFF
// - up/down mode toggles event flag on rollover; a set flag also requests the interrupt
//
// Added by the designer: the register addresses and register access over APB.
`default_nettype none

`include "tcrc_defs.svh"

module tcrc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  // APB slave
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  input  wire logic [3:0]        pstrb_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // Shared count / clock-out pin
  input  wire logic              shared_port_pin_in,
  output logic                   shared_port_pin_out,
  output logic                   shared_port_pin_oe_out,
  // Trigger / direction pin
  input  wire logic              trigger_direction_pin_in,
  // Serial port and interrupt side
  output logic                   baud_tick_out,
  output logic                   tx_baud_source_select_out,
  output logic                   rx_baud_source_select_out,
  output logic                   timer_irq_out
);

  // --------------------------------------------------------------
  // Address decode, shared by read and write paths
  // --------------------------------------------------------------
  localparam tcrc_pkg::tcrc_index_t IDX_CONTROL = 3'h0;
  localparam tcrc_pkg::tcrc_index_t IDX_MODE    = 3'h1;
  localparam tcrc_pkg::tcrc_index_t IDX_COUNT   = 3'h2;
  localparam tcrc_pkg::tcrc_index_t IDX_RELOAD  = 3'h3;
  localparam tcrc_pkg::tcrc_index_t IDX_IE      = 3'h4;
  localparam tcrc_pkg::tcrc_index_t IDX_NONE    = 3'h7;

  function automatic tcrc_pkg::tcrc_index_t decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [7:0] a;
    a = 8'(addr);
    case (a)
      `TCRC_OFS_CONTROL:    decode = IDX_CONTROL;
      `TCRC_OFS_MODE:       decode = IDX_MODE;
      `TCRC_OFS_COUNT:      decode = IDX_COUNT;
      `TCRC_OFS_RELOAD:     decode = IDX_RELOAD;
      `TCRC_OFS_INT_ENABLE: decode = IDX_IE;
      default:              decode = IDX_NONE;
    endcase
  endfunction

  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  logic [7:0]  timer_three_control_reg;
  logic [1:0]  timer_three_mode_reg;
  logic        interrupt_enable_reg;
  logic [15:0] count_reg;
  logic [15:0] reload_capture_reg;
  logic [3:0]  prescale_reg;
  logic        state_phase_reg;
  logic        clock_pin_reg;

  // Named views of control and mode bits
  logic capture_reload_select;
  logic timer_counter_select;
  logic run_control;
  logic external_trigger_enable;
  logic down_count_enable;
  logic clock_out_enable;
  logic overflow_flag;
  logic external_event_flag;

  assign capture_reload_select   =
    timer_three_control_reg[`TCRC_CTL_CAPTURE_RELOAD_SEL];
  assign timer_counter_select    =
    timer_three_control_reg[`TCRC_CTL_TIMER_COUNTER_SEL];
  assign run_control             =
    timer_three_control_reg[`TCRC_CTL_RUN_CONTROL];
  assign external_trigger_enable =
    timer_three_control_reg[`TCRC_CTL_EXT_TRIGGER_EN];
  assign overflow_flag           =
    timer_three_control_reg[`TCRC_CTL_OVERFLOW_FLAG];
  assign external_event_flag     =
    timer_three_control_reg[`TCRC_CTL_EXT_EVENT_FLAG];
  assign down_count_enable = timer_three_mode_reg[`TCRC_MODE_DOWN_COUNT_EN];
  assign clock_out_enable  = timer_three_mode_reg[`TCRC_MODE_CLOCK_OUT_EN];

  // --------------------------------------------------------------
  // Pin edges
  // --------------------------------------------------------------
  logic [1:0] pin_fall;

  tcrc_fall_detect #(
    .WIDTH (2)
  ) u_fall (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .level_in   ({trigger_direction_pin_in, shared_port_pin_in}),
    .fall_out   (pin_fall)
  );

  // --------------------------------------------------------------
  // APB access strobes
  // --------------------------------------------------------------
  tcrc_pkg::tcrc_index_t wr_idx;
  logic                  apb_wr;
  logic                  wr_ctl;
  logic                  wr_mode;
  logic                  wr_ie;
  logic                  wr_cnt;
  logic                  wr_rld;

  assign wr_idx  = decode(paddr_in);
  assign apb_wr  = psel_in & penable_in & pwrite_in & pready_out;
  assign wr_ctl  = apb_wr & (wr_idx == IDX_CONTROL) & pstrb_in[0];
  assign wr_mode = apb_wr & (wr_idx == IDX_MODE) & pstrb_in[0];
  assign wr_ie   = apb_wr & (wr_idx == IDX_IE) & pstrb_in[0];
  assign wr_cnt  = apb_wr & (wr_idx == IDX_COUNT);
  assign wr_rld  = apb_wr & (wr_idx == IDX_RELOAD);

  // --------------------------------------------------------------
  // Event logic
  // --------------------------------------------------------------
  tcrc_pkg::tcrc_mode_e mode;
  logic clock_out_active;
  logic fast_count;
  logic tick;
  logic up_down;
  logic count_up;
  logic roll_up;
  logic roll_down;
  logic rollover;
  logic trig_event;
  logic machine_tick;
  logic state_tick;

  // Mode from the baud selects and capture/reload select
  always_comb begin
    if (timer_three_control_reg[`TCRC_CTL_TX_BAUD_SEL] |
        timer_three_control_reg[`TCRC_CTL_RX_BAUD_SEL]) begin
      mode = tcrc_pkg::TCRC_MODE_BAUD;
    end else if (capture_reload_select) begin
      mode = tcrc_pkg::TCRC_MODE_CAPTURE;
    end else begin
      mode = tcrc_pkg::TCRC_MODE_RELOAD;
    end
  end

  assign machine_tick = (prescale_reg == (`TCRC_MACHINE_DIV - 4'h1));
  assign state_tick   = state_phase_reg;
  // Clock-out only runs from the internal source
  assign clock_out_active = clock_out_enable & ~timer_counter_select;
  assign fast_count = (mode == tcrc_pkg::TCRC_MODE_BAUD) | clock_out_active;

  // Increment source; nothing counts with run cleared
  always_comb begin
    if (!run_control) begin
      tick = 1'b0;
    end else if (timer_counter_select) begin
      tick = pin_fall[0];
    end else if (fast_count) begin
      tick = state_tick;
    end else begin
      tick = machine_tick;
    end
  end

  // Direction: up unless reload mode, down-count enabled and trigger low
  assign up_down  = (mode == tcrc_pkg::TCRC_MODE_RELOAD) & down_count_enable;
  assign count_up = ~up_down | trigger_direction_pin_in;

  assign roll_up    = tick & count_up & (count_reg == `TCRC_COUNT_TOP);
  assign roll_down  = tick & ~count_up &
                      (count_reg == reload_capture_reg);
  assign rollover   = roll_up | roll_down;
  // Trigger falls are ignored in up/down mode, where the pin is direction
  assign trig_event = pin_fall[1] & external_trigger_enable & ~up_down;

  // --------------------------------------------------------------
  // Prescalers: machine cycle and state time
  // --------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      prescale_reg    <= 4'h0;
      state_phase_reg <= 1'b0;
    end else begin
      if (machine_tick) begin
        prescale_reg <= 4'h0;
      end else begin
        prescale_reg <= prescale_reg + 4'h1;
      end
      // Two oscillator periods per state time
      state_phase_reg <= (`TCRC_STATE_DIV == 4'h2) ? ~state_phase_reg
                                                    : 1'b1;
    end
  end

  // --------------------------------------------------------------
  // Count register
  // --------------------------------------------------------------
  // Software writes win over counting; they are rare and deliberate
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_reg <= `TCRC_COUNT_RST;
    end else if (wr_cnt) begin
      if (pstrb_in[0]) begin
        count_reg[7:0] <= pwdata_in[7:0];
      end
      if (pstrb_in[1]) begin
        count_reg[15:8] <= pwdata_in[15:8];
      end
    end else if (roll_down) begin
      count_reg <= `TCRC_COUNT_TOP;
    end else if (roll_up) begin
      if (mode == tcrc_pkg::TCRC_MODE_CAPTURE) begin
        count_reg <= 16'h0000;
      end else begin
        count_reg <= reload_capture_reg;
      end
    end else if (trig_event && mode == tcrc_pkg::TCRC_MODE_RELOAD) begin
      count_reg <= reload_capture_reg;
    end else if (tick) begin
      count_reg <= count_up ? count_reg + 16'h0001
                            : count_reg - 16'h0001;
    end
  end

  // --------------------------------------------------------------
  // Reload / capture register
  // --------------------------------------------------------------
  // Capture wins over a software write in the same cycle
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reload_capture_reg <= `TCRC_RELOAD_RST;
    end else if (trig_event && mode == tcrc_pkg::TCRC_MODE_CAPTURE) begin
      reload_capture_reg <= count_reg;
    end else if (wr_rld) begin
      if (pstrb_in[0]) begin
        reload_capture_reg[7:0] <= pwdata_in[7:0];
      end
      if (pstrb_in[1]) begin
        reload_capture_reg[15:8] <= pwdata_in[15:8];
      end
    end
  end

  // --------------------------------------------------------------
  // Control register and flags
  // --------------------------------------------------------------
  logic [7:0] ctl_next;
  logic       tf_set;

  // Neither baud rollovers nor clock-out rollovers raise the flag
  assign tf_set = rollover & (mode != tcrc_pkg::TCRC_MODE_BAUD) &
                  ~clock_out_active;

  // Hardware setting a flag wins over a software clear
  always_comb begin
    ctl_next = wr_ctl ? pwdata_in[7:0] : timer_three_control_reg;
    if (tf_set) begin
      ctl_next[`TCRC_CTL_OVERFLOW_FLAG] = 1'b1;
    end
    if (up_down && rollover) begin
      ctl_next[`TCRC_CTL_EXT_EVENT_FLAG] =
        ~ctl_next[`TCRC_CTL_EXT_EVENT_FLAG];
    end else if (trig_event) begin
      ctl_next[`TCRC_CTL_EXT_EVENT_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_three_control_reg <= `TCRC_CONTROL_RST;
    end else begin
      timer_three_control_reg <= ctl_next;
    end
  end

  // Mode register; reset clears down-count enable
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_three_mode_reg <= `TCRC_MODE_RST;
    end else if (wr_mode) begin
      timer_three_mode_reg <= pwdata_in[1:0];
    end
  end

  // Interrupt enable bit
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      interrupt_enable_reg <= 1'b0;
    end else if (wr_ie) begin
      interrupt_enable_reg <= pwdata_in[`TCRC_IE_TIMER_EN];
    end
  end

  // --------------------------------------------------------------
  // Pin, baud and interrupt outputs
  // --------------------------------------------------------------
  // Toggle per rollover gives a 50% duty clock
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      clock_pin_reg          <= 1'b0;
      shared_port_pin_oe_out <= 1'b0;
    end else begin
      if (clock_out_active && rollover) begin
        clock_pin_reg <= ~clock_pin_reg;
      end
      shared_port_pin_oe_out <= clock_out_active;
    end
  end
  assign shared_port_pin_out = clock_pin_reg;

  // Same rollover feeds the serial port and the clock pin
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      baud_tick_out             <= 1'b0;
      tx_baud_source_select_out <= 1'b0;
      rx_baud_source_select_out <= 1'b0;
    end else begin
      baud_tick_out <= rollover & (mode == tcrc_pkg::TCRC_MODE_BAUD);
      // Same cycle's bits as the tick, so the two never disagree
      tx_baud_source_select_out <=
        timer_three_control_reg[`TCRC_CTL_TX_BAUD_SEL];
      rx_baud_source_select_out <=
        timer_three_control_reg[`TCRC_CTL_RX_BAUD_SEL];
    end
  end

  // One request for both flags; software polls to tell them apart
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      timer_irq_out <= 1'b0;
    end else begin
      timer_irq_out <= interrupt_enable_reg &
        (ctl_next[`TCRC_CTL_OVERFLOW_FLAG] |
         ctl_next[`TCRC_CTL_EXT_EVENT_FLAG]);
    end
  end

  // --------------------------------------------------------------
  // APB answer: ready one cycle after setup, data sampled at setup
  // --------------------------------------------------------------
  tcrc_pkg::tcrc_index_t rd_idx;
  logic [31:0]           rd_word;

  assign rd_idx = decode(paddr_in);

  always_comb begin
    case (rd_idx)
      IDX_CONTROL: rd_word = {24'h000000, timer_three_control_reg};
      IDX_MODE:    rd_word = {30'h00000000, timer_three_mode_reg};
      IDX_COUNT:   rd_word = {16'h0000, count_reg};
      IDX_RELOAD:  rd_word = {16'h0000, reload_capture_reg};
      IDX_IE:      rd_word = {31'h00000000, interrupt_enable_reg};
      default:     rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & (rd_idx == IDX_NONE);
      if (psel_in && !penable_in && !pwrite_in) begin
        prdata_out <= rd_word;
      end
    end
  end

endmodule

`default_nettype wire

//--- test/tcrc_pins.sv
// Pin-side model: pulled-up count pin and a trigger/direction pin.
// Assumes its tasks are called from the bench's clock domain.
`default_nettype none

module tcrc_pins (
  // Clock and design drive
  input  wire logic sys_clk_in,
  input  wire logic pin_out_in,
  input  wire logic pin_oe_in,
  // Levels seen by the design
  output logic      shared_level_out,
  output logic      trig_level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ext_lvl = 1'b1;

  initial trig_level_out = 1'b1;
  // Pull-up holds the pin high unless a party drives it
  assign shared_level_out = pin_oe_in ? pin_out_in : ext_lvl;

  // Falls on the count pin, low held two clocks, high three
  task automatic count_falls(input int n);
    repeat (n) begin
      @(posedge sys_clk_in) ext_lvl <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      ext_lvl <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
    end
  endtask

  // Trigger level: a fall captures or reloads, the level steers
  task automatic set_trig(input logic lvl);
    @(posedge sys_clk_in) trig_level_out <= lvl;
    repeat (2) @(posedge sys_clk_in);
  endtask
endmodule

`default_nettype wire

//--- test/tcrc_top_chk.sv
// Port checks on the timer block.
// Assumes one clock and the async active-high reset.
`default_nettype none

module tcrc_top_chk (
  // Clock, reset and APB
  input wire logic        sys_clk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  // Pin and side outputs
  input wire logic        shared_port_pin_out,
  input wire logic        shared_port_pin_oe_out,
  input wire logic        baud_tick_out,
  input wire logic        tx_baud_source_select_out,
  input wire logic        rx_baud_source_select_out,
  input wire logic        timer_irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic wr_done;

  // Finished write; outside up/down mode only software may clear sticky state
  assign wr_done = psel_in && penable_in && pwrite_in && pready_out;
  sequence s_setup;
    psel_in && !penable_in;
  endsequence
  sequence s_answer;
    pready_out ##1 !pready_out;
  endsequence

  a_apb_answer:
    assert property (s_setup |=> s_answer) else $error("bad access");
  a_ready_cause:
    assert property (pready_out |-> $past(psel_in && !penable_in))
    else $error("ready without setup");
  a_err_ready:
    assert property (pslverr_out |-> pready_out) else $error("lone err");
  a_rdata_hold:
    assert property ($changed(prdata_out) |->
      $past(psel_in && !penable_in && !pwrite_in)) else $error("rdata");
  a_irq_clear:
    assert property ($fell(timer_irq_out) |->
      $past(wr_done, 1) || $past(wr_done, 2)) else $error("irq fell");
  a_tick_single:
    assert property (baud_tick_out |=> !baud_tick_out)
    else $error("tick too long");
  a_tick_mode:
    assert property (baud_tick_out |->
      tx_baud_source_select_out || rx_baud_source_select_out)
    else $error("tick outside baud mode");
  a_clk_half:
    assert property (shared_port_pin_oe_out && $changed(shared_port_pin_out)
      |=> $stable(shared_port_pin_out)) else $error("clock too fast");
  a_oe_cause:
    assert property ($rose(shared_port_pin_oe_out) |->
      $past(wr_done, 1) || $past(wr_done, 2)) else $error("oe rose");
endmodule

bind tcrc_top tcrc_top_chk u_chk (
  .sys_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in,
  .prdata_out, .pready_out, .pslverr_out, .shared_port_pin_out,
  .shared_port_pin_oe_out, .baud_tick_out, .tx_baud_source_select_out,
  .rx_baud_source_select_out, .timer_irq_out
);

`default_nettype wire

//--- test/tcrc_top_tb.sv
// Self-checking bench for the timer block over APB.
// Assumes tcrc_pins drives the pins and the checker is bound.
`default_nettype none
`include "tcrc_defs.svh"

module tcrc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] CTL = `TCRC_OFS_CONTROL;
  localparam logic [7:0] MDE = `TCRC_OFS_MODE;
  localparam logic [7:0] CNT = `TCRC_OFS_COUNT;
  localparam logic [7:0] RLD = `TCRC_OFS_RELOAD;
  localparam logic [7:0] IEN = `TCRC_OFS_INT_ENABLE;
  logic        sys_clk_in, rst_in, psel_in, penable_in, pwrite_in;
  logic [7:0]  paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic [3:0]  pstrb_in;
  logic        pready_out, pslverr_out, perr, lv;
  logic        shared_port_pin_in, shared_port_pin_out;
  logic        shared_port_pin_oe_out, trigger_direction_pin_in;
  logic        baud_tick_out, timer_irq_out, txs, rxs;
  int          error_cnt, checked, cyc, n, nt;

  tcrc_top DUT (
    .sys_clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out,
    .shared_port_pin_in, .shared_port_pin_out, .shared_port_pin_oe_out,
    .trigger_direction_pin_in, .baud_tick_out, .timer_irq_out,
    .tx_baud_source_select_out(txs), .rx_baud_source_select_out(rxs)
  );
  tcrc_pins u_pins (
    .sys_clk_in, .pin_out_in(shared_port_pin_out),
    .pin_oe_in(shared_port_pin_oe_out),
    .shared_level_out(shared_port_pin_in),
    .trig_level_out(trigger_direction_pin_in)
  );

  // 25 MHz clock and a hang guard far beyond the run's length
  initial begin
    sys_clk_in = 1'b0;
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Setup, then access held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk_in);
    {psel_in, penable_in, pwrite_in} <= {2'b10, w};
    {paddr_in, pwdata_in} <= {a, d};
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    do @(posedge sys_clk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    perr = pslverr_out;
    {psel_in, penable_in} <= 2'b00;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic close_out;
    if (error_cnt == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {rst_in, psel_in, penable_in, pwrite_in} = 4'h8;
    {paddr_in, pwdata_in, pstrb_in} = 44'hF;
    repeat (5) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    // Reset state and an unmapped word
    rchk("mode", MDE, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", {31'h0, perr}, 32'h1);
    // Up reload, first held off by the run bit
    apb(1'b1, RLD, 32'h1234);
    apb(1'b1, CNT, 32'hFFFF);
    apb(1'b1, IEN, 32'h1);
    repeat (30) @(posedge sys_clk_in);
    rchk("idle", CNT, 32'hFFFF);
    apb(1'b1, CTL, 32'h4);
    repeat (30) @(posedge sys_clk_in);
    rchk("ovf", CTL, 32'h84);
    chk("irq", {31'h0, timer_irq_out}, 32'h1);
    apb(1'b0, CNT, 32'h0);
    chk("reload", {24'h0, rd[15:8]}, 32'h12);
    // Counter mode sees only falls on the shared pin
    apb(1'b1, CTL, 32'h0);
    apb(1'b1, CNT, 32'h0);
    apb(1'b1, CTL, 32'h6);
    u_pins.count_falls(5);
    rchk("events", CNT, 32'h5);
    // Capture with run off gives an exact copy
    apb(1'b1, CTL, 32'h0);
    apb(1'b1, CNT, 32'h5678);
    apb(1'b1, CTL, 32'h9);
    u_pins.set_trig(1'b0);
    rchk("capture", RLD, 32'h5678);
    rchk("event", CTL, 32'h49);
    chk("irq ev", {31'h0, timer_irq_out}, 32'h1);
    u_pins.set_trig(1'b1);
    apb(1'b1, CTL, 32'hD);
    repeat (30) @(posedge sys_clk_in);
    apb(1'b0, CNT, 32'h0);
    chk("counting", {31'h0, rd[15:0] > 16'h5678}, 32'h1);
    // Trigger fall reloads in reload mode, run off
    apb(1'b1, CTL, 32'h8);
    apb(1'b1, RLD, 32'hABCD);
    u_pins.set_trig(1'b0);
    rchk("trig", CNT, 32'hABCD);
    rchk("trig ctl", CTL, 32'h48);
    // Low trigger counts down; underflow loads FFFF
    apb(1'b1, CTL, 32'h0);
    apb(1'b1, MDE, 32'h1);
    apb(1'b1, RLD, 32'h10);
    apb(1'b1, CNT, 32'h12);
    apb(1'b1, CTL, 32'h4);
    repeat (40) @(posedge sys_clk_in);
    apb(1'b0, CNT, 32'h0);
    chk("under", {24'h0, rd[15:8]}, 32'hFF);
    rchk("toggle", CTL, 32'hC4);
    // Clock-out and baud tick from one rollover
    apb(1'b1, CTL, 32'h0);
    apb(1'b1, MDE, 32'h2);
    apb(1'b1, RLD, 32'hFFFE);
    apb(1'b1, CNT, 32'hFFFE);
    apb(1'b1, CTL, 32'h14);
    lv = shared_port_pin_out;
    while (shared_port_pin_out === lv) @(posedge sys_clk_in);
    lv = shared_port_pin_out;
    do begin
      @(posedge sys_clk_in);
      n++;
      nt += int'(baud_tick_out);
    end while (shared_port_pin_out === lv);
    chk("half", n, 32'h4);
    chk("ticks", nt, 32'h1);
    chk("oe", {31'h0, shared_port_pin_oe_out}, 32'h1);
    chk("baud sel", {30'h0, rxs, txs}, 32'h1);
    rchk("no ovf", CTL, 32'h14);
    // Clock-out alone in reload mode still raises no flag
    apb(1'b1, CTL, 32'h4);
    repeat (20) @(posedge sys_clk_in);
    rchk("co no ovf", CTL, 32'h4);
    close_out();
  end
endmodule

`default_nettype wire
